// ### pkg/boot_select_consts.svh
// Constants of the serial flash boot selector
`ifndef BOOT_SELECT_CONSTS_SVH
`define BOOT_SELECT_CONSTS_SVH
// Serial-port control register: byte address and reset value
`define SPC_ADDR 16'h2400
`define SPC_RESET 8'h02
// Field positions inside the serial-port control register
`define SPC_DUAL 0
`define SPC_SPEED 1
`define SPC_BOOTF 2
`define SPC_CARD 3
`define SPC_DONE 4
// Signature location and value ("2DFU" in ASCII)
`define SIG_ADDR 24'h00FFFA
`define SIG_VALUE 32'h32444655
// Code start addresses; the internal ROM start is a plain default
`define FLASH_START 16'h0000
`define ROM_START 16'hF000
// Flash read commands: single-bit and dual-output read
`define CMD_READ 8'h03
`define CMD_DREAD 8'h3B
// Bit counts of the flash transaction phases
`define HDR_LAST 6'h1F
`define DUMMY_LAST 6'h07
`define SIG_BITS 6'h20
`define BYTE_BITS 6'h08
`define STEP_ONE 6'h01
`define STEP_TWO 6'h02
// Slow serial clock: one tick every four system clocks
`define SLOW_DIV 2'h3
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### pkg/boot_select_pkg.sv
// Types of the serial flash boot selector
package boot_select_pkg;
  // Boot sequence: strap capture, probe, wait, run
  typedef enum logic [1:0] {
    B_STRAP = 2'b00,
    B_PROBE = 2'b01,
    B_WAIT = 2'b10,
    B_RUN = 2'b11
  } boot_state_t;
  // Flash transaction engine
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HDR = 3'b001,
    S_DUMMY = 3'b010,
    S_READ = 3'b011,
    S_END = 3'b100
  } spi_state_t;
endpackage

// ### src/serial_flash_boot_select.sv
// Boot-source selection over the serial flash, with speed strap capture
// What this block does
// - After reset, read flash from address 0xFFFA and check the boot signature.
// - Valid signature: use flash as code store, start fetch at 0x0000.
// - Bad signature or silent flash: keep running from internal ROM.
// - In reset, strap/data-out pin undriven with weak pull-down on.
// - On reset release, latch strap, then drive data out, pull-down off.
// - Strap high selects the fast serial clock; board pulls it high.
// - Serial-port control register at 0x2400 shows speed; resets to 0x02.
// - Flash reads work in single-bit and dual-bit data modes.
// - Flash parts in clock mode 0 and mode 3 both work.
// - In reset, card clock, command and data pads fully disabled.
`timescale 1ns/1ps
`include "boot_select_consts.svh"

module serial_flash_boot_select (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AXI4-Lite write address and data
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Flash pins; data-out pin doubles as speed strap and dual-bit line
  output logic flash_cs_n_o,
  output logic flash_sck_o,
  output logic flash_dout_o,
  output logic flash_dout_oe_o,
  output logic flash_dout_pd_o,
  input wire logic flash_dout_i,
  input wire logic flash_serial_in_i,
  // Card pad enables (clock, command, data)
  output logic card_pad_oe_o,
  output logic card_pad_ie_o,
  // Processor boot status and code fetch port
  output logic boot_done_o,
  output logic boot_from_flash_o,
  output logic [15:0] boot_pc_o,
  output logic spi_speed_o,
  input wire logic fetch_req_i,
  input wire logic [23:0] fetch_addr_i,
  output logic fetch_ready_o,
  output logic fetch_valid_o,
  output logic [7:0] fetch_data_o
);

  localparam logic [7:0] SPC_RST = `SPC_RESET;
  localparam logic [15:0] SPC_A = `SPC_ADDR;

  boot_select_pkg::boot_state_t bst_r;
  boot_select_pkg::spi_state_t st_r;

  // Strap and control state
  logic speed_r;
  logic pd_on_r;
  logic strap_done_r;
  logic dual_en_r;
  logic card_en_r;
  logic boot_flash_r;
  logic boot_done_r;
  logic [15:0] boot_pc_r;

  // Flash engine state
  logic [1:0] div_r;
  logic tick;
  logic sck_r;
  logic cs_n_r;
  logic dout_oe_r;
  logic [5:0] cnt_r;
  logic [5:0] want_r;
  logic use_dual_r;
  logic [31:0] tx_r;
  logic [31:0] rx_r;
  logic done_p_r;
  logic fetch_busy_r;
  logic fetch_valid_r;
  logic [7:0] fetch_data_r;

  // Engine start request
  logic go;
  logic go_probe;
  logic go_dual;
  logic [23:0] go_addr;

  // Bus slave state
  logic aw_got_r;
  logic w_got_r;
  logic [15:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] spc_val;

  // Latch the strap on the first clock after reset release
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      speed_r <= SPC_RST[`SPC_SPEED];
      pd_on_r <= 1'b1;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      speed_r <= flash_dout_i;
      pd_on_r <= 1'b0;
      strap_done_r <= 1'b1;
    end
  end

  // Slow rate divider; a high strap runs the serial clock every cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign tick = speed_r | (div_r == `SLOW_DIV);

  // Start terms: the probe is always single-bit, fetches follow the mode
  assign go_probe = (bst_r == boot_select_pkg::B_PROBE);
  assign fetch_ready_o = (bst_r == boot_select_pkg::B_RUN) & boot_flash_r
    & (st_r == boot_select_pkg::S_IDLE) & !fetch_busy_r;
  assign go = go_probe | (fetch_req_i & fetch_ready_o);
  assign go_dual = !go_probe & dual_en_r;
  assign go_addr = go_probe ? `SIG_ADDR : fetch_addr_i;

  // Flash transaction engine: data changes on falling sck, sampled on
  // rising sck, with sck idle low, which suits mode 0 and mode 3 parts
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r <= boot_select_pkg::S_IDLE;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      dout_oe_r <= 1'b0;
      cnt_r <= 6'h00;
      want_r <= 6'h00;
      use_dual_r <= 1'b0;
      tx_r <= 32'h0000_0000;
      rx_r <= 32'h0000_0000;
      done_p_r <= 1'b0;
    end else begin
      done_p_r <= 1'b0;
      unique case (st_r)
        boot_select_pkg::S_IDLE: begin
          cs_n_r <= 1'b1;
          sck_r <= 1'b0;
          dout_oe_r <= strap_done_r;
          if (go) begin
            st_r <= boot_select_pkg::S_HDR;
            cs_n_r <= 1'b0;
            cnt_r <= 6'h00;
            use_dual_r <= go_dual;
            want_r <= go_probe ? `SIG_BITS : `BYTE_BITS;
            tx_r <= {go_dual ? `CMD_DREAD : `CMD_READ, go_addr};
          end
        end
        boot_select_pkg::S_HDR: begin
          if (tick) begin
            if (!sck_r) begin
              sck_r <= 1'b1;
            end else begin
              sck_r <= 1'b0;
              tx_r <= {tx_r[30:0], 1'b0};
              cnt_r <= cnt_r + `STEP_ONE;
              if (cnt_r == `HDR_LAST) begin
                cnt_r <= 6'h00;
                if (use_dual_r) begin
                  // Release the line: the flash drives it after the dummies
                  st_r <= boot_select_pkg::S_DUMMY;
                  dout_oe_r <= 1'b0;
                end else begin
                  st_r <= boot_select_pkg::S_READ;
                end
              end
            end
          end
        end
        boot_select_pkg::S_DUMMY: begin
          if (tick) begin
            if (!sck_r) begin
              sck_r <= 1'b1;
            end else begin
              sck_r <= 1'b0;
              cnt_r <= cnt_r + `STEP_ONE;
              if (cnt_r == `DUMMY_LAST) begin
                cnt_r <= 6'h00;
                st_r <= boot_select_pkg::S_READ;
              end
            end
          end
        end
        boot_select_pkg::S_READ: begin
          if (tick) begin
            if (!sck_r) begin
              sck_r <= 1'b1;
              if (use_dual_r) begin
                rx_r <= {rx_r[29:0], flash_serial_in_i, flash_dout_i};
                cnt_r <= cnt_r + `STEP_TWO;
              end else begin
                rx_r <= {rx_r[30:0], flash_serial_in_i};
                cnt_r <= cnt_r + `STEP_ONE;
              end
            end else begin
              sck_r <= 1'b0;
              if (cnt_r >= want_r) begin
                st_r <= boot_select_pkg::S_END;
              end
            end
          end
        end
        boot_select_pkg::S_END: begin
          cs_n_r <= 1'b1;
          sck_r <= 1'b0;
          dout_oe_r <= 1'b1;
          done_p_r <= 1'b1;
          st_r <= boot_select_pkg::S_IDLE;
        end
        default: begin
          st_r <= boot_select_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Boot sequence; a missing flash reads as all zero through the
  // pull-down and so fails the signature check
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bst_r <= boot_select_pkg::B_STRAP;
      boot_flash_r <= 1'b0;
      boot_done_r <= 1'b0;
      boot_pc_r <= `ROM_START;
    end else begin
      unique case (bst_r)
        boot_select_pkg::B_STRAP: begin
          bst_r <= boot_select_pkg::B_PROBE;
        end
        boot_select_pkg::B_PROBE: begin
          bst_r <= boot_select_pkg::B_WAIT;
        end
        boot_select_pkg::B_WAIT: begin
          if (done_p_r) begin
            bst_r <= boot_select_pkg::B_RUN;
            boot_done_r <= 1'b1;
            if (rx_r == `SIG_VALUE) begin
              boot_flash_r <= 1'b1;
              boot_pc_r <= `FLASH_START;
            end else begin
              boot_flash_r <= 1'b0;
              boot_pc_r <= `ROM_START;
            end
          end
        end
        boot_select_pkg::B_RUN: begin
          bst_r <= boot_select_pkg::B_RUN;
        end
      endcase
    end
  end

  // Code fetch from flash once the flash was chosen
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fetch_busy_r <= 1'b0;
      fetch_valid_r <= 1'b0;
      fetch_data_r <= 8'h00;
    end else begin
      fetch_valid_r <= 1'b0;
      if (fetch_req_i && fetch_ready_o) begin
        fetch_busy_r <= 1'b1;
      end else if (done_p_r && fetch_busy_r) begin
        fetch_busy_r <= 1'b0;
        fetch_valid_r <= 1'b1;
        fetch_data_r <= rx_r[7:0];
      end
    end
  end

  // Pin drive; reset overrides the flops so pins hold from time zero
  assign flash_cs_n_o = cs_n_r | rst_i;
  assign flash_sck_o = sck_r & ~rst_i;
  assign flash_dout_o = tx_r[31];
  assign flash_dout_oe_o = dout_oe_r & ~rst_i;
  assign flash_dout_pd_o = pd_on_r | rst_i;
  assign card_pad_oe_o = card_en_r & ~rst_i;
  assign card_pad_ie_o = card_en_r & ~rst_i;

  // Status toward the processor
  assign boot_done_o = boot_done_r;
  assign boot_from_flash_o = boot_flash_r;
  assign boot_pc_o = boot_pc_r;
  assign spi_speed_o = speed_r;
  assign fetch_valid_o = fetch_valid_r;
  assign fetch_data_o = fetch_data_r;

  // Register view; upper bits read as zero
  assign spc_val = {3'h0, boot_done_r, card_en_r, boot_flash_r,
    speed_r, dual_en_r};

  // Write channel: address and data taken in either order
  assign s_axi_awready_o = !aw_got_r && !bvalid_r;
  assign s_axi_wready_o = !w_got_r && !bvalid_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wr_hit = (awaddr_r[15:2] == SPC_A[15:2]);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 16'h0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;

  // Writable control bits; the rest of the register is read only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dual_en_r <= SPC_RST[`SPC_DUAL];
      card_en_r <= SPC_RST[`SPC_CARD];
    end else if (wr_fire && wr_hit && wstrb_r[0]) begin
      dual_en_r <= wdata_r[`SPC_DUAL];
      card_en_r <= wdata_r[`SPC_CARD];
    end
  end

  // Read channel: one read at a time, answered a cycle after it is taken
  assign s_axi_arready_o = !rvalid_r;
  assign rd_hit = (s_axi_araddr_i[15:2] == SPC_A[15:2]);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r <= rd_hit ? {24'h00_0000, spc_val} : 32'h0000_0000;
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rresp_o = rresp_r;
  assign s_axi_rdata_o = rdata_r;

endmodule

// ### testbench/boot_select_chk.sv
// Port checker of the serial flash boot selector
`timescale 1ns/1ps
`include "boot_select_consts.svh"
module boot_select_chk (
  // Clock, reset and bus read answer
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  // Flash and card pads
  input wire logic flash_cs_n_o,
  input wire logic flash_sck_o,
  input wire logic flash_dout_oe_o,
  input wire logic flash_dout_pd_o,
  input wire logic flash_dout_i,
  input wire logic card_pad_oe_o,
  input wire logic card_pad_ie_o,
  // Boot status and fetch port
  input wire logic boot_done_o,
  input wire logic boot_from_flash_o,
  input wire logic [15:0] boot_pc_o,
  input wire logic spi_speed_o,
  input wire logic fetch_ready_o,
  input wire logic fetch_valid_o
);
  // One clock domain; reset checks cannot be disabled by reset itself
  default clocking cb @(posedge sys_clk_i); endclocking
  chk_reset_flash: assert property (
    rst_i |-> flash_cs_n_o && !flash_sck_o)
    else $error("flash pins active in reset");
  chk_reset_strap: assert property (
    rst_i |-> !flash_dout_oe_o && flash_dout_pd_o)
    else $error("strap pin driven in reset");
  chk_card_pads_off: assert property (
    rst_i |-> !card_pad_oe_o && !card_pad_ie_o)
    else $error("card pads enabled in reset");
  chk_strap_latch: assert property (disable iff (rst_i)
    $fell(rst_i) |=> spi_speed_o == $past(flash_dout_i) && !flash_dout_pd_o)
    else $error("strap not latched at release");
  chk_probe_start: assert property (disable iff (rst_i)
    $fell(rst_i) |-> ##[1:8] !flash_cs_n_o)
    else $error("probe did not start");
  chk_probe_ends: assert property (disable iff (rst_i)
    $fell(flash_cs_n_o) && !boot_done_o |-> ##[1:800] boot_done_o)
    else $error("probe did not finish");
  chk_pc_select: assert property (disable iff (rst_i) boot_done_o |->
    boot_pc_o == (boot_from_flash_o ? `FLASH_START : `ROM_START))
    else $error("wrong start address");
  chk_rom_no_fetch: assert property (disable iff (rst_i)
    boot_done_o && !boot_from_flash_o |-> !fetch_ready_o && !fetch_valid_o)
    else $error("flash fetch in ROM boot");
  chk_speed_field: assert property (disable iff (rst_i)
    s_axi_rvalid_o && s_axi_rresp_o == `RESP_OKAY |->
    s_axi_rdata_o[`SPC_SPEED] == spi_speed_o)
    else $error("speed field differs from strap");
endmodule
bind serial_flash_boot_select boot_select_chk u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .flash_cs_n_o(flash_cs_n_o), .flash_sck_o(flash_sck_o),
  .flash_dout_oe_o(flash_dout_oe_o), .flash_dout_pd_o(flash_dout_pd_o),
  .flash_dout_i(flash_dout_i), .card_pad_oe_o(card_pad_oe_o),
  .card_pad_ie_o(card_pad_ie_o), .boot_done_o(boot_done_o),
  .boot_from_flash_o(boot_from_flash_o), .boot_pc_o(boot_pc_o),
  .spi_speed_o(spi_speed_o), .fetch_ready_o(fetch_ready_o),
  .fetch_valid_o(fetch_valid_o)
);

// ### testbench/flash_model.sv
// Behavioural serial flash on the far side of the boot selector
`timescale 1ns/1ps
module flash_model (
  // Pins from the block
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  // Bench controls: part fitted, signature intact
  input wire logic present_i,
  input wire logic sig_ok_i,
  // Data back to the block
  output logic so_o,
  output logic io0_o,
  output logic io0_oe_o
);
  logic [31:0] hdr_r;
  int cnt_r;
  // Pattern contents with the signature at 0xFFFA; 24-bit space
  function automatic logic [7:0] mem(input logic [23:0] a);
    case (a)
      24'h00FFFA: mem = 8'h32;
      24'h00FFFB: mem = 8'h44;
      24'h00FFFC: mem = 8'h46;
      24'h00FFFD: mem = sig_ok_i ? 8'h55 : 8'h54;
      default: mem = a[7:0] ^ 8'hA5;
    endcase
  endfunction
  initial {so_o, io0_o, io0_oe_o} = 3'h0;
  // Sample on rising edges: fits clock mode 0 and mode 3 alike
  always @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_r <= 0;
    end else begin
      if (cnt_r < 32) hdr_r <= {hdr_r[30:0], si_i};
      cnt_r <= cnt_r + 1;
    end
  end
  // Shift out on falling edges so data settle before the next rise
  always @(negedge sck_i or posedge cs_n_i) begin
    int p;
    logic [7:0] b;
    if (cs_n_i || !present_i) begin
      so_o <= 1'b0; // Released line sits at its pull-down
      io0_oe_o <= 1'b0;
    end else if (hdr_r[31:24] == 8'h03 && cnt_r >= 32) begin
      p = cnt_r - 32;
      b = mem(hdr_r[23:0] + 24'(p / 8));
      so_o <= b[7 - p % 8];
    end else if (hdr_r[31:24] == 8'h3B && cnt_r >= 40) begin
      p = cnt_r - 40;
      b = mem(hdr_r[23:0] + 24'(p / 4));
      so_o <= b[7 - 2 * (p % 4)];
      io0_o <= b[6 - 2 * (p % 4)];
      io0_oe_o <= 1'b1;
    end
  end
endmodule

// ### testbench/serial_flash_boot_select_bench.sv
// Self-checking bench of the serial flash boot selector
`timescale 1ns/1ps
`include "boot_select_consts.svh"
module serial_flash_boot_select_bench;
  logic sys_clk_i, rst_i, awv, wv, bre, arv, rre, freq, strap_r;
  logic present_r, sig_r, awr, wr, bv, arr, rv, cs_n, sck, dq, dq_oe;
  logic pd, so, io0, io0_oe, cpo, cpi, done, from_f, spd, frdy, fv;
  logic [15:0] awa, ara, pc;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [23:0] fa;
  logic [1:0] br, rr;
  logic [7:0] fd, reg_m;
  logic [7:0] exp_q[$];
  int bad_count, num_checks;
  // Pin level: block, then flash IO0, else the board strap resistor
  wire pin = dq_oe ? dq : (io0_oe ? io0 : strap_r);
  serial_flash_boot_select i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .flash_cs_n_o(cs_n), .flash_sck_o(sck),
    .flash_dout_o(dq), .flash_dout_oe_o(dq_oe), .flash_dout_pd_o(pd),
    .flash_dout_i(pin), .flash_serial_in_i(so), .card_pad_oe_o(cpo),
    .card_pad_ie_o(cpi), .boot_done_o(done), .boot_from_flash_o(from_f),
    .boot_pc_o(pc), .spi_speed_o(spd), .fetch_req_i(freq),
    .fetch_addr_i(fa), .fetch_ready_o(frdy), .fetch_valid_o(fv),
    .fetch_data_o(fd));
  flash_model i_flash (.cs_n_i(cs_n), .sck_i(sck), .si_i(pin),
    .present_i(present_r), .sig_ok_i(sig_r), .so_o(so), .io0_o(io0),
    .io0_oe_o(io0_oe));
  // 20 MHz system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // A wait that ran out ends the run
  task automatic lost(input string n);
    bad_count++;
    $display("mismatch %s expected answer seen none", n);
    test_done();
  endtask
  // Handshakes are judged at the edge, before that edge's updates land
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] e);
    int n;
    @(posedge sys_clk_i);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk_i);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    if (n == 50) lost("bvalid");
    bre <= 1'b0;
    cmp("bresp", 32'(e), 32'(br));
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge sys_clk_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk_i);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    if (n == 50) lost("rvalid");
    rre <= 1'b0;
    cmp("rresp", 32'(er), 32'(rr));
    cmp("rdata", e, rd);
  endtask
  task automatic fetch(input logic [23:0] a);
    int n;
    @(posedge sys_clk_i);
    freq <= 1'b1;
    fa <= a;
    // Request stands until the edge that sees ready high, never released
    // in the same step it was raised
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk_i);
      if (frdy === 1'b1) break;
    end
    if (n == 50) lost("fetch ready");
    freq <= 1'b0;
    exp_q.push_back(a[7:0] ^ 8'hA5);
    for (n = 0; n < 400 && fv !== 1'b1; n++) @(posedge sys_clk_i);
    if (n == 400) lost("fetch valid");
    cmp("fetch data", 32'(exp_q.pop_front()), 32'(fd));
  endtask
  // Reset with a given strap and flash, then judge the boot choice
  task automatic boot(input logic st, input logic sg, input logic pr);
    int n;
    logic [15:0] pc_e;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    strap_r <= st;
    sig_r <= sg;
    present_r <= pr;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd_reg(`SPC_ADDR, 32'(st) << 1, `RESP_OKAY);
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge sys_clk_i);
    if (n == 3000) lost("boot done");
    cmp("from flash", 32'(sg & pr), 32'(from_f));
    pc_e = (sg & pr) ? `FLASH_START : `ROM_START;
    cmp("boot pc", 32'(pc_e), 32'(pc));
    reg_m = {3'h0, 1'b1, 1'b0, sg & pr, st, 1'b0};
    rd_reg(`SPC_ADDR, 32'(reg_m), `RESP_OKAY);
    cmp("fetch ready", 32'(sg & pr), 32'(frdy));
    cmp("card pads", 32'h0, {30'h0, cpo, cpi});
  endtask
  initial begin
    rst_i = 1'b1;
    {awv, wv, bre, arv, rre, freq} = 6'h0;
    awa = 16'h0;
    ara = 16'h0;
    wd = 32'h0;
    ws = 4'h0;
    fa = 24'h0;
    {strap_r, present_r, sig_r} = 3'h7;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(32'h9219));
    // Flash boot at full speed, register kinds, both fetch widths
    boot(1'b1, 1'b1, 1'b1);
    wr_reg(`SPC_ADDR, $urandom | 32'h9, 4'h1, `RESP_OKAY);
    rd_reg(`SPC_ADDR, 32'h1F, `RESP_OKAY);
    cmp("card pads", 32'h3, {30'h0, cpo, cpi});
    wr_reg(`SPC_ADDR, 32'h0, 4'h0, `RESP_OKAY);
    rd_reg(`SPC_ADDR, 32'h1F, `RESP_OKAY);
    wr_reg(16'h2404, 32'h0, 4'hF, `RESP_SLVERR);
    rd_reg(16'h2404, 32'h0, `RESP_SLVERR);
    repeat (3) fetch(24'($urandom) & 24'h7FFF);
    wr_reg(`SPC_ADDR, 32'h8, 4'h1, `RESP_OKAY);
    repeat (3) fetch(24'($urandom) & 24'h7FFF);
    $display("test flash boot done");
    boot(1'b0, 1'b0, 1'b1);
    $display("test bad signature done");
    boot(1'b1, 1'b1, 1'b0);
    $display("test no flash done");
    test_done();
  end
endmodule
